// >>> core/twe_pkg.sv
// constants, offsets and state codes of the two-wire memory slave
package twe_pkg;
  // slave address prefixes
  localparam logic [3:0] PFX_MEM = 4'hA;
  localparam logic [3:0] PFX_PROT = 4'h6;
  // protocol counts
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int ARRAY_WORDS = 256;
  // timing: internal programming cycle
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS = 5000;
  localparam int PROG_CYCLES_INT = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] PROG_CYCLES = PROG_CYCLES_INT[15:0];
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_POINTER = 8'h08;
  // control field positions and reset value
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  // status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PROT_BIT = 1;
  localparam int STAT_STANDBY_BIT = 2;
  localparam int STAT_SEL_BIT = 3;
  localparam int STAT_INHIBIT_BIT = 4;
  // protocol engine states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_RX = 8'h04,
    ST_ACK = 8'h08,
    ST_TX = 8'h10,
    ST_RACK = 8'h20,
    ST_WAITSTOP = 8'h40,
    ST_PROG = 8'h80
  } twe_state_e;
endpackage

// >>> core/twe_slave.sv
// two-wire serial memory slave with byte write, read stream and write protection
//
// Behaviour
// - start is sda falling while scl high; every command opens with one.
// - stop is sda rising while scl high; master ends each transaction so.
// - a stop ending a read sequence puts the device into standby.
// - sda changes only while scl low; changes during scl high mean start/stop.
// - transmitter releases sda after eight bits; receiver pulls low on ninth clock.
// - first byte is slave address; prefix 1010 memory access, 0110 protect command.
// - address bits 3..1 compare to straps select2, select1, select0.
// - address bit 0 selects direction: 1 read, 0 write.
// - acknowledge only after start plus matching address; mismatch leaves sda released.
// - once selected for write, acknowledge every following received byte.
// - in read, release after eight bits, sample ninth clock, ack sends next byte.
// - in read, no acknowledge stops sending, releases sda, waits for stop.
// - sda is open drain: pulled low or released only.
// - write inhibit high suppresses all programming; low allows writes.
// - write inhibit input weakly pulled low so floating means writes enabled.
// - protect command sets the software write protect state.
// - protection blocks writes to 00..7F forever, surviving power loss; here hresetn clears sw_prot_reg.
// - write inhibit high blocks the whole array regardless of protection.
// - byte write sends eight-bit word address after address ack; device acks it.
// - after word address ack, accept one data byte and acknowledge it.
// - stop ending a byte write starts the programming cycle.
// - during programming inputs ignored and nothing acknowledged.
// - protect command acks word address and data, ignores values; stop programs.
// - after protection programmed, further protect commands have no effect.
`timescale 1ns/1ns
`default_nettype none

module twe_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_inhibit_input,
  input wire logic strap_select_bit0,
  input wire logic strap_select_bit1,
  input wire logic strap_select_bit2,
  output logic standby
);

  // decides whether a pending write may be programmed
  function automatic logic write_blocked(input logic prot_cmd, input logic [7:0] waddr,
                                         input logic inhibit, input logic prot_set);
    if (prot_cmd) begin
      write_blocked = inhibit | prot_set;
    end else begin
      write_blocked = inhibit | (prot_set & ~waddr[7]);
    end
  endfunction

  localparam int ARRAY_WORDS = twe_pkg::ARRAY_WORDS;

  twe_pkg::twe_state_e state_reg;
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [3:0] pin_s1, pin_s2;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [7:0] rx_sr, tx_sr, word_addr, data_reg, addr_ptr;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic rd_mode, prot_cmd, data_got, acked;
  logic sw_prot_reg, standby_reg, ctrl_en_reg;
  logic [15:0] prog_cnt;
  logic prog_start, prog_done, addr_match, inhibit, bus_ok;
  logic [2:0] straps;
  logic [7:0] mem [ARRAY_WORDS];
  logic ahb_wr_pend;
  logic [7:0] ahb_wr_addr;
  logic ahb_valid;

  // two-stage synchronisers plus a history stage for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else if (clk_en) begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // straps and write inhibit also cross in through two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 4'h0; // inhibit reads low, as its pull-down would
      pin_s2 <= 4'h0;
    end else if (clk_en) begin
      pin_s1 <= {write_inhibit_input, strap_select_bit2, strap_select_bit1, strap_select_bit0};
      pin_s2 <= pin_s1;
    end
  end

  assign inhibit = pin_s2[3]; // steady through a transaction by the controller
  assign straps = pin_s2[2:0];

  // line events seen on the synchronised samples
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_ev = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_ev = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // address compare on a completed first byte
  assign addr_match = ((rx_sr[7:4] == twe_pkg::PFX_MEM) ||
                       ((rx_sr[7:4] == twe_pkg::PFX_PROT) && !rx_sr[0])) &&
                      (rx_sr[3:1] == straps);

  assign bus_ok = ctrl_en_reg && (state_reg != twe_pkg::ST_PROG);
  assign prog_start = bus_ok && stop_ev && data_got && !rd_mode &&
                      !write_blocked(prot_cmd, word_addr, inhibit, sw_prot_reg);
  assign prog_done = (state_reg == twe_pkg::ST_PROG) && (prog_cnt == 16'h0000);

  // protocol engine: bit counting, address match, acknowledge and transmit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= twe_pkg::ST_IDLE;
      rx_sr <= 8'h00;
      tx_sr <= 8'h00;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      rd_mode <= 1'b0;
      prot_cmd <= 1'b0;
      data_got <= 1'b0;
      acked <= 1'b0;
      word_addr <= 8'h00;
      data_reg <= 8'h00;
      addr_ptr <= 8'h00;
      sda_oe <= 1'b0;
      standby_reg <= 1'b1;
    end else if (clk_en) begin
      if (state_reg == twe_pkg::ST_PROG) begin
        sda_oe <= 1'b0; // inputs ignored while programming
        if (prog_done) begin
          state_reg <= twe_pkg::ST_IDLE;
        end
      end else if (!ctrl_en_reg) begin
        state_reg <= twe_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (stop_ev) begin
        sda_oe <= 1'b0;
        data_got <= 1'b0;
        standby_reg <= 1'b1;
        state_reg <= prog_start ? twe_pkg::ST_PROG : twe_pkg::ST_IDLE;
      end else if (start_ev) begin
        sda_oe <= 1'b0;
        bit_cnt <= 4'h0;
        data_got <= 1'b0;
        standby_reg <= 1'b0;
        state_reg <= twe_pkg::ST_ADDR;
      end else begin
        case (state_reg)
          twe_pkg::ST_ADDR, twe_pkg::ST_RX: begin
            if (scl_rise) begin
              rx_sr <= {rx_sr[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == twe_pkg::BITS_PER_BYTE) begin
              if (state_reg == twe_pkg::ST_ADDR) begin
                if (addr_match) begin
                  sda_oe <= 1'b1;
                  rd_mode <= rx_sr[0];
                  prot_cmd <= (rx_sr[7:4] == twe_pkg::PFX_PROT);
                  byte_idx <= 2'h1;
                  state_reg <= twe_pkg::ST_ACK;
                end else begin
                  state_reg <= twe_pkg::ST_WAITSTOP; // sda stays released
                end
              end else begin
                if (byte_idx == 2'h1) begin
                  word_addr <= rx_sr;
                  if (!prot_cmd) begin
                    addr_ptr <= rx_sr;
                  end
                  byte_idx <= 2'h2;
                end else begin
                  data_reg <= rx_sr;
                  data_got <= 1'b1;
                end
                sda_oe <= 1'b1;
                state_reg <= twe_pkg::ST_ACK;
              end
            end
          end
          twe_pkg::ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rd_mode) begin
                tx_sr <= mem[addr_ptr];
                sda_oe <= ~mem[addr_ptr][7]; // pull low only for a zero
                addr_ptr <= addr_ptr + 8'h01;
                state_reg <= twe_pkg::ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state_reg <= twe_pkg::ST_RX;
              end
            end
          end
          twe_pkg::ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == twe_pkg::BITS_PER_BYTE) begin
                sda_oe <= 1'b0;
                state_reg <= twe_pkg::ST_RACK;
              end else begin
                sda_oe <= ~tx_sr[6]; // change only while scl low
                tx_sr <= {tx_sr[6:0], 1'b0};
              end
            end
          end
          twe_pkg::ST_RACK: begin
            if (scl_rise) begin
              acked <= ~sda_s2; // ninth clock sample
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (acked) begin
                tx_sr <= mem[addr_ptr];
                sda_oe <= ~mem[addr_ptr][7];
                addr_ptr <= addr_ptr + 8'h01;
                state_reg <= twe_pkg::ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state_reg <= twe_pkg::ST_WAITSTOP;
              end
            end
          end
          twe_pkg::ST_WAITSTOP: begin
            sda_oe <= 1'b0; // wait for stop or a new start
          end
          twe_pkg::ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state_reg <= twe_pkg::ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // programming cycle timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_cnt <= 16'h0000;
    end else if (clk_en) begin
      if (prog_start) begin
        prog_cnt <= twe_pkg::PROG_CYCLES - 16'h0001;
      end else if (prog_cnt != 16'h0000) begin
        prog_cnt <= prog_cnt - 16'h0001;
      end
    end
  end

  // array programming at the end of the cycle
  always_ff @(posedge hclk) begin
    if (clk_en && prog_done && !prot_cmd) begin
      mem[word_addr] <= data_reg;
    end
  end

  // software protect flag: set once, never cleared by the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_prot_reg <= 1'b0;
    end else if (clk_en && prog_done && prot_cmd) begin
      sw_prot_reg <= 1'b1;
    end
  end

  // register bus: address phase capture
  assign ahb_valid = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_pend <= 1'b0;
      ahb_wr_addr <= 8'h00;
    end else if (clk_en) begin
      ahb_wr_pend <= ahb_valid & hwrite;
      ahb_wr_addr <= haddr[7:0];
    end
  end

  // control register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_reg <= twe_pkg::CTRL_EN_RESET;
    end else if (clk_en && ahb_wr_pend && ahb_wr_addr == twe_pkg::REG_CTRL) begin
      ctrl_en_reg <= hwdata[twe_pkg::CTRL_EN_BIT];
    end
  end

  // read data registered at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (clk_en) begin
      hrdata <= 32'h00000000;
      if (ahb_valid && !hwrite && haddr[31:8] == 24'h000000) begin
        case (haddr[7:0])
          twe_pkg::REG_CTRL: begin
            hrdata[twe_pkg::CTRL_EN_BIT] <= ctrl_en_reg;
          end
          twe_pkg::REG_STATUS: begin
            hrdata[twe_pkg::STAT_BUSY_BIT] <= (state_reg == twe_pkg::ST_PROG);
            hrdata[twe_pkg::STAT_PROT_BIT] <= sw_prot_reg;
            hrdata[twe_pkg::STAT_STANDBY_BIT] <= standby_reg;
            hrdata[twe_pkg::STAT_SEL_BIT] <= (state_reg != twe_pkg::ST_IDLE) &&
                                             (state_reg != twe_pkg::ST_WAITSTOP) &&
                                             (state_reg != twe_pkg::ST_PROG);
            hrdata[twe_pkg::STAT_INHIBIT_BIT] <= inhibit;
          end
          twe_pkg::REG_POINTER: begin
            hrdata[7:0] <= addr_ptr;
          end
          default: begin
            hrdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // bus answers: stall only while the clock enable freezes state
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign standby = standby_reg;

endmodule // twe_slave

`default_nettype wire

// >>> core/unused_placeholder_none.sv
// intentionally empty compile unit
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> sim/twe_checker.sv
// port assertions for the two-wire memory slave
`timescale 1ns/1ns
`default_nettype none
module twe_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic standby
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // pin and bus relations
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved with scl high");
  bit_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("low bit too short");
  ack_selected_a: assert property (sda_oe |-> !standby)
    else $error("sda pulled in standby");
  start_wake_a: assert property ($fell(standby) |-> scl_in && !sda_in)
    else $error("wake without start");
  stop_sleep_a: assert property ($rose(standby) |-> scl_in && sda_in)
    else $error("standby without stop");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  rdata_idle_a: assert property (clk_en && !(hsel && htrans[1] && !hwrite && hready)
    |=> hrdata == 32'h0)
    else $error("read data lingers");
  // main scenarios
  ack_c: cover property ($rose(sda_oe) && scl_in == 1'b0);
  wake_c: cover property ($fell(standby));
  read_c: cover property (hrdata != 32'h0);
endmodule // twe_checker
bind twe_slave twe_checker chk_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hresp(hresp), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .standby(standby));
`default_nettype wire

// >>> sim/twe_master.sv
// behavioural two-wire bus master: drives scl, pulls sda low
`timescale 1ns/1ns
`default_nettype none
module twe_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // bus idle: clock high and still, sda released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // sda falls while scl high, held so the slave sees it
  task automatic start();
    #200 sda_low = 1'b0;
    #200 scl = 1'b1;
    #400 sda_low = 1'b1;
    #600 scl = 1'b0;
  endtask
  // sda rises while scl high, then clock stands high
  task automatic stop();
    #200 sda_low = 1'b1;
    #200 scl = 1'b1;
    #400 sda_low = 1'b0;
    #400;
  endtask
  // msb first, data moved only with scl low, released for the ack
  task automatic wr(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #200 sda_low = !b[i];
      #200 scl = 1'b1;
      #400 scl = 1'b0;
    end
    #200 sda_low = 1'b0;
    #200 scl = 1'b1;
    #200 ack = !sda;
    #200 scl = 1'b0;
  endtask
  // receive a byte, then pull low on the ninth clock to ask for more
  task automatic rd(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #200 sda_low = 1'b0;
      #200 scl = 1'b1;
      #200 b[i] = sda;
      #200 scl = 1'b0;
    end
    #200 sda_low = ack;
    #200 scl = 1'b1;
    #400 scl = 1'b0;
  endtask
endmodule // twe_master
`default_nettype wire

// >>> sim/twe_slave_bench.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ns
`default_nettype none
module twe_slave_bench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic scl, m_low, sda_out, sda_oe, inhibit, standby, k;
  logic [7:0] v;
  wire logic sda;
  int n_mismatch, compares;
  assign hready = hreadyout;
  // pulled-up wire, low while any party pulls it
  assign sda = !(m_low || sda_oe);
  twe_master m (.scl(scl), .sda_low(m_low), .sda(sda));
  twe_slave uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_inhibit_input(inhibit), .strap_select_bit0(1'b1),
    .strap_select_bit1(1'b0), .strap_select_bit2(1'b1), .standby(standby));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = !hclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one single ahb transfer, waits on hready in both phases
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic xfer(input logic [7:0] b, input logic e);
    m.wr(b, k);
    chk(32'(k), 32'(e));
  endtask
  // ack polling: first answer shows busy, then ack must come
  task automatic poll(input logic busy);
    m.start();
    m.wr(8'hAA, k);
    m.stop();
    chk(32'(k), 32'(!busy));
    for (int i = 0; i < 6 && k !== 1'b1; i++) begin
      m.start();
      m.wr(8'hAA, k);
      m.stop();
    end
    chk(32'(k), 32'h1);
  endtask
  task automatic cmd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d,
    input logic busy);
    m.start();
    xfer(p, 1'b1);
    xfer(a, 1'b1);
    xfer(d, 1'b1);
    m.stop();
    poll(busy);
  endtask
  // random read of two bytes, then nack and one silent byte
  task automatic bread(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    m.start();
    xfer(8'hAA, 1'b1);
    xfer(a, 1'b1);
    m.start();
    xfer(8'hAB, 1'b1);
    m.rd(1'b1, v);
    chk(32'(v), 32'(d0));
    m.rd(1'b0, v);
    chk(32'(v), 32'(d1));
    m.rd(1'b0, v);
    chk(32'(v), 32'hFF);
    m.stop();
    chk(32'(standby), 32'h1);
  endtask
  task automatic t_regs();
    ahb(32'h04, 1'b0, 32'h0);
    chk(q, 32'h04);
    ahb(32'h00, 1'b0, 32'h0);
    chk(q, 32'h01);
    ahb(32'h0C, 1'b0, 32'h0);
    chk(q, 32'h00);
  endtask
  // wrong straps, read-mode protect, bus disabled: no ack
  task automatic t_select();
    m.start();
    xfer(8'hA8, 1'b0);
    m.start();
    xfer(8'h6B, 1'b0);
    m.stop();
    ahb(32'h00, 1'b1, 32'h0);
    m.start();
    xfer(8'hAA, 1'b0);
    m.stop();
    ahb(32'h00, 1'b1, 32'h1);
  endtask
  task automatic t_write();
    cmd(8'hAA, 8'h7F, 8'h11, 1'b1);
    cmd(8'hAA, 8'h80, 8'h22, 1'b1);
    bread(8'h7F, 8'h11, 8'h22);
    ahb(32'h08, 1'b0, 32'h0);
    chk(q, 32'h81);
  endtask
  // inhibit moves only between stop and start
  task automatic t_inhibit();
    @(posedge hclk);
    inhibit <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(32'h04, 1'b0, 32'h0);
    chk(q, 32'h14);
    cmd(8'hAA, 8'h80, 8'h55, 1'b0);
    @(posedge hclk);
    inhibit <= 1'b0;
    bread(8'h7F, 8'h11, 8'h22);
  endtask
  task automatic t_protect();
    cmd(8'h6A, 8'h00, 8'hFF, 1'b1);
    ahb(32'h04, 1'b0, 32'h0);
    chk(q, 32'h06);
    cmd(8'hAA, 8'h7F, 8'hEE, 1'b0);
    cmd(8'hAA, 8'h80, 8'h33, 1'b1);
    bread(8'h7F, 8'h11, 8'h33);
    cmd(8'h6A, 8'h00, 8'hFF, 1'b0);
  endtask
  // reset, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    inhibit = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_regs();
    t_select();
    t_write();
    t_inhibit();
    t_protect();
    tally_and_finish();
  end
  // watchdog against a hung handshake
  initial begin
    #3000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // twe_slave_bench
`default_nettype wire
